// [hdl/iepr_pkg.sv]
// Constants and types for the interrupt enable and priority registers
package iepr_pkg;

  localparam int IEPR_AW = 8;
  localparam int IEPR_DW = 16;
  localparam int IEPR_PW = 3;

  // Byte addresses on the register port
  localparam logic [7:0] A_FLG4 = 8'h80;
  localparam logic [7:0] A_FLG5 = 8'h82;
  localparam logic [7:0] A_FLG6 = 8'h84;
  localparam logic [7:0] A_IEN4 = 8'hA0;
  localparam logic [7:0] A_IEN5 = 8'hA2;
  localparam logic [7:0] A_IEN6 = 8'hA4;
  localparam logic [7:0] A_PRI0 = 8'hA8;
  localparam logic [7:0] A_PRI1 = 8'hAA;

  // Source bit positions, shared by flag and enable registers
  localparam int B_CC2 = 0;
  localparam int B_CC4 = 15;
  localparam int B_CC3 = 14;
  localparam int B_USB = 6;
  localparam int B_I2CB = 5;
  localparam int B_I2CA = 4;
  localparam int B_TS = 14;
  localparam int B_OSC = 10;
  localparam int B_LC4 = 3;
  localparam int B_LC3 = 2;
  localparam int B_LC2 = 1;
  localparam int B_LC1 = 0;

  // Implemented bits; all others read as zero
  localparam logic [15:0] M_REG4 = 16'h0001;
  localparam logic [15:0] M_REG5 = 16'hC070;
  localparam logic [15:0] M_REG6 = 16'h440F;
  localparam logic [15:0] M_PRI0 = 16'h7777;
  localparam logic [15:0] M_PRI1 = 16'h7007;

  // Priority field low bits
  localparam int P_HI = 12;
  localparam int P_MH = 8;
  localparam int P_ML = 4;
  localparam int P_LO = 0;

  localparam logic [2:0] PRIO_DEF = 3'h4;
  localparam logic [15:0] RST_EN = 16'h0000;
  localparam logic [15:0] RST_PRI0 = {1'b0, PRIO_DEF, 1'b0, PRIO_DEF,
                                      1'b0, PRIO_DEF, 1'b0, PRIO_DEF};
  localparam logic [15:0] RST_PRI1 = RST_PRI0 & M_PRI1;

  typedef struct packed {
    logic [IEPR_AW-1:0] addr;
    logic [IEPR_DW-1:0] wdata;
    logic wr;
    logic rd;
  } iepr_bus_t;

  typedef struct packed {
    logic capcomp_four;
    logic capcomp_three;
    logic capcomp_two;
    logic usb;
    logic i2c_b_collision;
    logic i2c_a_collision;
    logic timestamp;
    logic osc_selftune;
    logic logic_cell_four;
    logic logic_cell_three;
    logic logic_cell_two;
    logic logic_cell_one;
  } iepr_src_t;

  typedef struct packed {
    logic [IEPR_PW-1:0] timer_one_prio;
    logic [IEPR_PW-1:0] cct_two_prio;
    logic [IEPR_PW-1:0] cct_one_prio;
    logic [IEPR_PW-1:0] ext_irq_zero_prio;
    logic [IEPR_PW-1:0] timer_two_prio;
    logic [IEPR_PW-1:0] dma_zero_prio;
  } iepr_prio_t;

  typedef struct packed {
    logic [IEPR_DW-1:0] ien4;
    logic [IEPR_DW-1:0] ien5;
    logic [IEPR_DW-1:0] ien6;
    logic [IEPR_DW-1:0] flg4;
    logic [IEPR_DW-1:0] flg5;
    logic [IEPR_DW-1:0] flg6;
    logic [IEPR_DW-1:0] pri0;
    logic [IEPR_DW-1:0] pri1;
    logic [IEPR_DW-1:0] rdata;
    iepr_src_t req;
    logic irq;
  } iepr_state_t;

endpackage

// [hdl/iepr_regs.sv]
// Interrupt enable, flag and priority registers with request gating
//
// Overview of operation
// RQ1: Priority fields are three bits; level 7 highest, level 0 lowest.
// RQ2: Every priority field resets to level 4.
// RQ3: Register five bit 6 enables the USB request.
// RQ4: Register five bits 5 and 4 enable I2C 2 and I2C 1 collision requests.
// RQ5: Register five bits 15 and 14 enable capture/compare 4 and 3.
// RQ6: Register six bit 14 enables the timestamp request.
// RQ7: Register six bit 10 enables the oscillator self-tuning request.
// RQ8: Register six bits 3 to 0 enable logic cells 4 to 1.
// RQ9: Register four bit 0 enables the capture/compare 2 request.
// RQ10: Priority zero bits 14:12 Timer1, bits 10:8 capture/compare/timer 2.
// RQ11: Priority zero bits 6:4 capture/compare/timer 1, bits 2:0 external 0.
// RQ12: Priority one bits 14:12 Timer2, bits 2:0 DMA channel 0.
// RQ13: A flag reads 1 once its event occurred, regardless of enable.
// RQ14: Clearing an enable masks the forwarded request, not the flag.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps

module iepr_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire iepr_pkg::iepr_bus_t bus,
  output logic [iepr_pkg::IEPR_DW-1:0] rdata,
  input wire iepr_pkg::iepr_src_t events,
  output iepr_pkg::iepr_src_t req,
  output iepr_pkg::iepr_prio_t prio,
  output logic irq
);

  iepr_pkg::iepr_state_t st_q;
  iepr_pkg::iepr_state_t st_d;

  function automatic logic hit(
    input logic [iepr_pkg::IEPR_AW-1:0] a,
    input logic [iepr_pkg::IEPR_AW-1:0] off
  );
    hit = (a == off);
  endfunction

  // Set wins over a simultaneous write-one clear
  function automatic logic [iepr_pkg::IEPR_DW-1:0] w1c(
    input logic [iepr_pkg::IEPR_DW-1:0] flag,
    input logic [iepr_pkg::IEPR_DW-1:0] set,
    input logic [iepr_pkg::IEPR_DW-1:0] clr,
    input logic [iepr_pkg::IEPR_DW-1:0] msk
  );
    w1c = ((flag & ~clr) | set) & msk;
  endfunction

  function automatic logic [iepr_pkg::IEPR_PW-1:0] fld(
    input logic [iepr_pkg::IEPR_DW-1:0] r,
    input int lsb
  );
    fld = r[lsb +: iepr_pkg::IEPR_PW];
  endfunction

  logic [iepr_pkg::IEPR_DW-1:0] set4;
  logic [iepr_pkg::IEPR_DW-1:0] set5;
  logic [iepr_pkg::IEPR_DW-1:0] set6;
  logic [iepr_pkg::IEPR_DW-1:0] clr4;
  logic [iepr_pkg::IEPR_DW-1:0] clr5;
  logic [iepr_pkg::IEPR_DW-1:0] clr6;
  logic [iepr_pkg::IEPR_DW-1:0] pend4;
  logic [iepr_pkg::IEPR_DW-1:0] pend5;
  logic [iepr_pkg::IEPR_DW-1:0] pend6;

  always_comb begin
    st_d = st_q;
    set4 = '0;
    set5 = '0;
    set6 = '0;
    clr4 = '0;
    clr5 = '0;
    clr6 = '0;

    // Event inputs placed at their flag positions
    set4[iepr_pkg::B_CC2] = events.capcomp_two;
    set5[iepr_pkg::B_CC4] = events.capcomp_four;
    set5[iepr_pkg::B_CC3] = events.capcomp_three;
    set5[iepr_pkg::B_USB] = events.usb;
    set5[iepr_pkg::B_I2CB] = events.i2c_b_collision;
    set5[iepr_pkg::B_I2CA] = events.i2c_a_collision;
    set6[iepr_pkg::B_TS] = events.timestamp;
    set6[iepr_pkg::B_OSC] = events.osc_selftune;
    set6[iepr_pkg::B_LC4] = events.logic_cell_four;
    set6[iepr_pkg::B_LC3] = events.logic_cell_three;
    set6[iepr_pkg::B_LC2] = events.logic_cell_two;
    set6[iepr_pkg::B_LC1] = events.logic_cell_one;

    if (bus.wr) begin
      if (hit(bus.addr, iepr_pkg::A_FLG4)) begin
        clr4 = bus.wdata;
      end
      if (hit(bus.addr, iepr_pkg::A_FLG5)) begin
        clr5 = bus.wdata;
      end
      if (hit(bus.addr, iepr_pkg::A_FLG6)) begin
        clr6 = bus.wdata;
      end
      if (hit(bus.addr, iepr_pkg::A_IEN4)) begin
        st_d.ien4 = bus.wdata & iepr_pkg::M_REG4; // RQ9
      end
      if (hit(bus.addr, iepr_pkg::A_IEN5)) begin
        st_d.ien5 = bus.wdata & iepr_pkg::M_REG5; // RQ3 RQ4 RQ5
      end
      if (hit(bus.addr, iepr_pkg::A_IEN6)) begin
        st_d.ien6 = bus.wdata & iepr_pkg::M_REG6; // RQ6 RQ7 RQ8
      end
      if (hit(bus.addr, iepr_pkg::A_PRI0)) begin
        st_d.pri0 = bus.wdata & iepr_pkg::M_PRI0; // RQ1 RQ10 RQ11
      end
      if (hit(bus.addr, iepr_pkg::A_PRI1)) begin
        st_d.pri1 = bus.wdata & iepr_pkg::M_PRI1; // RQ1 RQ12
      end
    end

    // Flags are set by events and cleared by write-one only; enables never touch them
    st_d.flg4 = w1c(st_q.flg4, set4, clr4, iepr_pkg::M_REG4); // RQ13 RQ14
    st_d.flg5 = w1c(st_q.flg5, set5, clr5, iepr_pkg::M_REG5); // RQ13 RQ14
    st_d.flg6 = w1c(st_q.flg6, set6, clr6, iepr_pkg::M_REG6); // RQ13 RQ14

    // Requests forwarded to the core: pending flag and enable
    pend4 = st_d.flg4 & st_d.ien4; // RQ14
    pend5 = st_d.flg5 & st_d.ien5; // RQ14
    pend6 = st_d.flg6 & st_d.ien6; // RQ14
    st_d.req.capcomp_two = pend4[iepr_pkg::B_CC2]; // RQ9
    st_d.req.capcomp_four = pend5[iepr_pkg::B_CC4]; // RQ5
    st_d.req.capcomp_three = pend5[iepr_pkg::B_CC3]; // RQ5
    st_d.req.usb = pend5[iepr_pkg::B_USB]; // RQ3
    st_d.req.i2c_b_collision = pend5[iepr_pkg::B_I2CB]; // RQ4
    st_d.req.i2c_a_collision = pend5[iepr_pkg::B_I2CA]; // RQ4
    st_d.req.timestamp = pend6[iepr_pkg::B_TS]; // RQ6
    st_d.req.osc_selftune = pend6[iepr_pkg::B_OSC]; // RQ7
    st_d.req.logic_cell_four = pend6[iepr_pkg::B_LC4]; // RQ8
    st_d.req.logic_cell_three = pend6[iepr_pkg::B_LC3]; // RQ8
    st_d.req.logic_cell_two = pend6[iepr_pkg::B_LC2]; // RQ8
    st_d.req.logic_cell_one = pend6[iepr_pkg::B_LC1]; // RQ8
    st_d.irq = |{pend4, pend5, pend6};

    // Read data valid in the cycle after the strobe only
    st_d.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        iepr_pkg::A_FLG4: st_d.rdata = st_q.flg4; // RQ13
        iepr_pkg::A_FLG5: st_d.rdata = st_q.flg5; // RQ13
        iepr_pkg::A_FLG6: st_d.rdata = st_q.flg6; // RQ13
        iepr_pkg::A_IEN4: st_d.rdata = st_q.ien4;
        iepr_pkg::A_IEN5: st_d.rdata = st_q.ien5;
        iepr_pkg::A_IEN6: st_d.rdata = st_q.ien6;
        iepr_pkg::A_PRI0: st_d.rdata = st_q.pri0;
        iepr_pkg::A_PRI1: st_d.rdata = st_q.pri1;
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.ien4 <= iepr_pkg::RST_EN;
      st_q.ien5 <= iepr_pkg::RST_EN;
      st_q.ien6 <= iepr_pkg::RST_EN;
      st_q.pri0 <= iepr_pkg::RST_PRI0; // RQ2
      st_q.pri1 <= iepr_pkg::RST_PRI1; // RQ2
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign req = st_q.req;
  assign irq = st_q.irq;

  // Priority levels straight from the register bits
  assign prio.timer_one_prio = fld(st_q.pri0, iepr_pkg::P_HI); // RQ10
  assign prio.cct_two_prio = fld(st_q.pri0, iepr_pkg::P_MH); // RQ10
  assign prio.cct_one_prio = fld(st_q.pri0, iepr_pkg::P_ML); // RQ11
  assign prio.ext_irq_zero_prio = fld(st_q.pri0, iepr_pkg::P_LO); // RQ11
  assign prio.timer_two_prio = fld(st_q.pri1, iepr_pkg::P_HI); // RQ12
  assign prio.dma_zero_prio = fld(st_q.pri1, iepr_pkg::P_LO); // RQ12

endmodule

// [verification/iepr_regs_chk.sv]
// Port assertions for the enable and priority registers
`timescale 1ns/100ps
module iepr_regs_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire iepr_pkg::iepr_bus_t bus,
  input wire logic [iepr_pkg::IEPR_DW-1:0] rdata,
  input wire iepr_pkg::iepr_src_t events,
  input wire iepr_pkg::iepr_src_t req,
  input wire iepr_pkg::iepr_prio_t prio,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic w4, w5, w6;
  assign w4 = bus.wr && bus.addr == iepr_pkg::A_IEN4 && bus.wdata == '0;
  assign w5 = bus.wr && bus.addr == iepr_pkg::A_IEN5;
  assign w6 = bus.wr && bus.addr == iepr_pkg::A_IEN6 && bus.wdata == '0;
  property p_rst;
    $past(!reset_n) |-> prio == {6{iepr_pkg::PRIO_DEF}};
  endproperty
  a_rst: assert property (p_rst) else $error("bad prio reset");
  property p_keep;
    !bus.wr |=> $stable(prio);
  endproperty
  a_keep: assert property (p_keep) else $error("prio moved");
  property p_irq;
    irq == (req != '0);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not req");
  property p_usb;
    $rose(req.usb) |-> $past(events.usb) || $past(w5 && bus.wdata[6]);
  endproperty
  a_usb: assert property (p_usb) else $error("usb req cause");
  property p_m5;
    w5 && bus.wdata == '0 |=> {req[11:10], req[8:6]} == '0;
  endproperty
  a_m5: assert property (p_m5) else $error("reg5 mask");
  property p_m6;
    w6 |=> req[5:0] == '0;
  endproperty
  a_m6: assert property (p_m6) else $error("reg6 mask");
  property p_m4;
    w4 |=> !req.capcomp_two;
  endproperty
  a_m4: assert property (p_m4) else $error("reg4 mask");
  property p_p0;
    bus.wr && bus.addr == iepr_pkg::A_PRI0 |=> prio[17:6] ==
      {$past(bus.wdata[14:12]), $past(bus.wdata[10:8]),
       $past(bus.wdata[6:4]), $past(bus.wdata[2:0])};
  endproperty
  a_p0: assert property (p_p0) else $error("prio0 fields");
  property p_p1;
    bus.wr && bus.addr == iepr_pkg::A_PRI1 |=> prio[5:0] ==
      {$past(bus.wdata[14:12]), $past(bus.wdata[2:0])};
  endproperty
  a_p1: assert property (p_p1) else $error("prio1 fields");
endmodule
bind iepr_regs iepr_regs_chk iepr_regs_chk_i (.clk(clk), .reset_n(reset_n),
  .bus(bus), .rdata(rdata), .events(events), .req(req), .prio(prio),
  .irq(irq));

// [verification/iepr_src_model.sv]
// Peripheral event sources: one-cycle event pulse on command
`timescale 1ns/100ps
module iepr_src_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fire,
  input wire logic [3:0] idx,
  output iepr_pkg::iepr_src_t events
);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      events <= '0;
    end else begin
      events <= fire ? iepr_pkg::iepr_src_t'(12'h001 << idx) : '0;
    end
  end
endmodule

// [verification/test_irq_enable_priority_regs.sv]
// Self-checking bench for the enable and priority registers
`timescale 1ns/100ps
module test_irq_enable_priority_regs;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic fire = 1'b0;
  logic [3:0] idx = 4'h0;
  iepr_pkg::iepr_bus_t bus = '0;
  logic [15:0] rdata;
  iepr_pkg::iepr_src_t events;
  iepr_pkg::iepr_src_t req;
  iepr_pkg::iepr_prio_t prio;
  logic irq;
  logic [15:0] rv;
  int n_errors = 0;
  int n_tests = 0;
  logic [7:0] fa [12] = '{8'h84, 8'h84, 8'h84, 8'h84, 8'h84, 8'h84,
                          8'h82, 8'h82, 8'h82, 8'h80, 8'h82, 8'h82};
  int fb [12] = '{0, 1, 2, 3, 10, 14, 4, 5, 6, 0, 14, 15};
  always #10 clk = ~clk;
  iepr_src_model iepr_src_model_i (.clk(clk), .reset_n(reset_n),
    .fire(fire), .idx(idx), .events(events));
  iepr_regs iepr_regs_i (.clk(clk), .reset_n(reset_n), .bus(bus),
    .rdata(rdata), .events(events), .req(req), .prio(prio), .irq(irq));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 rv = rdata;
    chk(rv, e);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    fire <= 1'b1;
    idx <= 4'(i);
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic t_reset();
    #1;
    chk(prio, {6{3'h4}});
    rchk(8'hA8, 16'h4444);
    rchk(8'hAA, 16'h4004);
    rchk(8'hA2, 16'h0000);
    rchk(8'hA4, 16'h0000);
  endtask
  task automatic t_en();
    wr(8'hA0, 16'hFFFF);
    rchk(8'hA0, 16'h0001);
    wr(8'hA2, 16'hFFFF);
    rchk(8'hA2, 16'hC070);
    wr(8'hA4, 16'hFFFF);
    rchk(8'hA4, 16'h440F);
    wr(8'hB0, 16'hFFFF);
    rchk(8'hB0, 16'h0000);
    rchk(8'hA0, 16'h0001);
  endtask
  task automatic t_prio();
    logic [2:0] l;
    for (int k = 0; k < 8; k++) begin
      l = 3'(k);
      wr(8'hA8, {1'b0, l, 1'b0, l + 3'h1, 1'b0, l + 3'h2, 1'b0, l + 3'h3});
      chk(prio[17:6], {l, l + 3'h1, l + 3'h2, l + 3'h3});
      wr(8'hAA, {1'b1, l, 8'hFF, 1'b1, l + 3'h5});
      chk(prio[5:0], {l, l + 3'h5});
    end
    rchk(8'hAA, 16'h7004);
  endtask
  task automatic t_src();
    for (int i = 0; i < 12; i++) begin
      pulse(i);
      chk(req, 18'h1 << i);
      chk(irq, 1'b1);
      rchk(fa[i], 16'h0001 << fb[i]);
      wr(fa[i], 16'h0001 << fb[i]);
      chk(req, 18'h0);
    end
  endtask
  task automatic t_mask();
    wr(8'hA2, 16'h0000);
    pulse(8);
    chk({irq, req}, 18'h0);
    rchk(8'h82, 16'h0040);
    wr(8'hA2, 16'h0040);
    chk({irq, req}, 18'h1100);
  endtask
  // Event and write-one clear of the same flag in one cycle: set wins
  task automatic t_race();
    @(posedge clk);
    fire <= 1'b1;
    idx <= 4'h8;
    @(posedge clk);
    fire <= 1'b0;
    bus <= '{addr: 8'h82, wdata: 16'h0040, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    #1;
    chk({irq, req}, 18'h1100);
    rchk(8'h82, 16'h0040);
    wr(8'h82, 16'h0040);
    chk({irq, req}, 18'h0);
    rchk(8'h82, 16'h0000);
  endtask
  // Reset in mid-run after priorities, enables and a flag were changed
  task automatic t_rerst();
    pulse(8);
    chk(req, 18'h100);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk(prio, {6{3'h4}});
    chk({irq, req}, 18'h0);
    rchk(8'hA8, 16'h4444);
    rchk(8'hAA, 16'h4004);
    rchk(8'h82, 16'h0000);
    rchk(8'hA2, 16'h0000);
  endtask
  initial begin
    #1000000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_en();
    t_prio();
    t_src();
    t_mask();
    t_race();
    t_rerst();
    end_sim();
  end
endmodule
